// ==== include/uirm_pkg.sv ====
// Package of the serial port interrupt and register map block.
// Assumes byte addresses on a 32-bit APB with aligned words.
package uirm_pkg;
	localparam logic [31:0] BASE_ADDR  = 32'h4030_0000;
	localparam logic [6:0]  OFS_DATA   = 7'h00;
	localparam logic [6:0]  OFS_ERR    = 7'h04;
	localparam logic [6:0]  OFS_TMO    = 7'h0C;
	localparam logic [6:0]  OFS_FLAGS  = 7'h18;
	localparam logic [6:0]  OFS_RXFMT  = 7'h1C;
	localparam logic [6:0]  OFS_BAUDI  = 7'h24;
	localparam logic [6:0]  OFS_BAUDF  = 7'h28;
	localparam logic [6:0]  OFS_TXFMT  = 7'h2C;
	localparam logic [6:0]  OFS_CTRL   = 7'h30;
	localparam logic [6:0]  OFS_THR    = 7'h34;
	localparam logic [6:0]  OFS_MASK   = 7'h38;
	localparam logic [6:0]  OFS_RAW    = 7'h3C;
	localparam logic [6:0]  OFS_MIS    = 7'h40;
	localparam logic [6:0]  OFS_ICLR   = 7'h44;
	localparam logic [6:0]  OFS_DMA    = 7'h48;
	localparam logic [6:0]  OFS_SFC    = 7'h50;
	localparam logic [6:0]  OFS_RES1   = 7'h54;
	localparam logic [6:0]  OFS_PAU2   = 7'h60;
	localparam logic [31:0] RST_TMO    = 32'h0000_01FF;
	localparam logic [31:0] RST_FLAGS  = 32'h0000_1E90;
	localparam logic [31:0] RST_CTRL   = 32'h0004_0300;
	localparam logic [31:0] RST_THR    = 32'h0000_0012;
	localparam logic [31:0] FLG_FIXED  = 32'h0000_1E00;
	localparam int          FEN_BIT    = 4;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_TXE   = 8;
	localparam int          CTRL_RXE   = 9;
	localparam int          THR_TX_LSB = 0;
	localparam int          THR_RX_LSB = 3;
	localparam int          ERR_FE     = 0;
	localparam int          ERR_PE     = 1;
	localparam int          ERR_BE     = 2;
	localparam int          ERR_OE     = 3;
	localparam int          IRQ_RX     = 4;
	localparam int          IRQ_TX     = 5;
	localparam int          IRQ_RT     = 6;
	localparam int          IRQ_FE     = 7;
	localparam int          IRQ_PE     = 8;
	localparam int          IRQ_BE     = 9;
	localparam int          IRQ_OE     = 10;
	localparam int          IRQ_TXFE   = 12;
	localparam int          IRQ_W      = 13;
	localparam int          FLG_BUSY   = 3;
	localparam int          FLG_RXFE   = 4;
	localparam int          FLG_TXFF   = 5;
	localparam int          FLG_RXFF   = 6;
	localparam int          FLG_TXFE   = 7;
	localparam int          CHAR_W     = 8;
endpackage

// ==== verilog/uirm_fifo.sv ====
// Character FIFO with a run-time capacity limit (depth or one entry).
// Assumes the owner never pushes when full nor pops when empty.
`timescale 1ns/100ps
module uirm_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	input  wire logic [$clog2(DEPTH+1)-1:0]   limit,
	input  wire logic                         push,
	input  wire logic [WIDTH-1:0]             pushData,
	input  wire logic                         pop,
	output logic      [WIDTH-1:0]             popData,
	output logic      [$clog2(DEPTH+1)-1:0]   count,
	output logic                              full,
	output logic                              empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("uirm_fifo: DEPTH must be a power of two");
	end

	assign popData = mem[rdPtr_r];
	assign full    = count >= limit;
	assign empty   = count == '0;

	// Storage has no reset: only words below count are ever read
	always_ff @(posedge clk) begin
		if (ce && push)
			mem[wrPtr_r] <= pushData;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count   <= '0;
		end else if (ce) begin
			if (push)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (pop)
				rdPtr_r <= rdPtr_r + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // uirm_fifo

// ==== verilog/uirm_regmap.sv ====
// Register map, character FIFOs and interrupt sources of a serial port.
// Assumes a serial engine that delivers received characters with their
// fault flags, takes transmit characters, and gives one tick per bit.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module uirm_regmap import uirm_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [31:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rxCharValid,
	input  wire logic [CHAR_W-1:0] rxChar,
	input  wire logic              framingFault,
	input  wire logic              parityFault,
	input  wire logic              lineBreakFault,
	input  wire logic              rxStartBit,
	input  wire logic              bitTick,
	input  wire logic              txCharTake,
	input  wire logic              txShiftBusy,
	output logic                   txCharValid,
	output logic      [CHAR_W-1:0] txChar,
	output logic                   uartIrq,
	output logic      [31:0]       uartControl,
	output logic      [31:0]       rxLineFormat,
	output logic      [31:0]       txLineFormat,
	output logic      [31:0]       baudDivInt,
	output logic      [31:0]       baudDivFrac,
	output logic      [31:0]       dmaRequestControl,
	output logic      [31:0]       softFlowControl
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int RXW = CHAR_W + 3;

	initial begin
		if (FIFO_DEPTH < 8 || FIFO_DEPTH % 8 != 0)
			$error("uirm_regmap: FIFO_DEPTH must be a multiple of 8");
	end

	// Watermark in characters from a 3-bit threshold code
	function automatic logic [CW-1:0] wmLevel(input logic [2:0] sel);
		int lvl;
		case (sel)
			3'h0: lvl = FIFO_DEPTH / 8;
			3'h1: lvl = FIFO_DEPTH / 4;
			3'h2: lvl = FIFO_DEPTH / 2;
			3'h3: lvl = FIFO_DEPTH * 3 / 4;
			default: lvl = FIFO_DEPTH * 7 / 8;
		endcase
		return CW'(lvl);
	endfunction

	function automatic logic isMapped(input logic [6:0] ofs);
		case (ofs)
			OFS_DATA, OFS_ERR, OFS_TMO, OFS_FLAGS, OFS_RXFMT,
			OFS_BAUDI, OFS_BAUDF, OFS_TXFMT, OFS_CTRL, OFS_THR,
			OFS_MASK, OFS_RAW, OFS_MIS, OFS_ICLR, OFS_DMA,
			OFS_SFC: return 1'b1;
			default: return ofs >= OFS_RES1 && ofs <= OFS_PAU2;
		endcase
	endfunction

	logic [31:0]        idleTimeout_r;
	logic [31:0]        threshold_r;
	logic [31:0]        lineFlags_r;
	logic [IRQ_W-1:0]   irqMask_r;
	logic [IRQ_W-1:0]   irqRaw_r;
	logic [IRQ_W-1:0]   irqRaw_nxt;
	logic [IRQ_W-1:0]   irqSet;
	logic [IRQ_W-1:0]   irqClr;
	logic [3:0]         errStatus_r;
	logic [CHAR_W-1:0]  flowChar_r [4];
	logic [31:0]        idleCnt_r;
	logic               rxCondPrev_r;
	logic               txCondPrev_r;
	logic               txPopPrev_r;
	logic               busyPrev_r;
	logic [31:0]        rdData;
	logic [6:0]         ofs;
	logic               hit;
	logic               acc;
	logic               wrAcc;
	logic               rdAcc;
	logic [1:0]         charIdx;
	logic               rxEnabled;
	logic               rxPush;
	logic               rxOverrun;
	logic               rxPop;
	logic [RXW-1:0]     rxHead;
	logic [CW-1:0]      rxCount;
	logic               rxFull;
	logic               rxEmpty;
	logic               txPush;
	logic               txPop;
	logic [CHAR_W-1:0]  txHead;
	logic [CW-1:0]      txCount;
	logic               txFull;
	logic               txEmpty;
	logic [CW-1:0]      rxLimit;
	logic [CW-1:0]      txLimit;
	logic               rxCond;
	logic               txCond;
	logic               busy;
	logic               rtSet;

	// Address decode within the block's window
	assign ofs     = paddr[6:0];
	assign hit     = paddr[31:7] == BASE_ADDR[31:7] && paddr[1:0] == 2'b00
		&& isMapped(ofs);
	assign acc     = psel && penable && pready;
	assign wrAcc   = acc && pwrite && hit;
	assign rdAcc   = acc && !pwrite && hit;
	assign charIdx = 2'((ofs - OFS_RES1) >> 2);

	// One entry when the FIFO enable bit of the line format is low
	assign rxLimit = rxLineFormat[FEN_BIT] ? CW'(FIFO_DEPTH) : CW'(1);
	assign txLimit = txLineFormat[FEN_BIT] ? CW'(FIFO_DEPTH) : CW'(1);

	assign rxEnabled = uartControl[CTRL_EN] && uartControl[CTRL_RXE];
	assign rxPush    = ce && rxCharValid && rxEnabled && !rxFull;
	assign rxOverrun = ce && rxCharValid && rxEnabled && rxFull;
	assign rxPop     = ce && rdAcc && ofs == OFS_DATA && !rxEmpty;

	// Writes into a full transmit FIFO are dropped
	assign txPush = ce && wrAcc && ofs == OFS_DATA && !txFull;
	assign txPop  = ce && !txEmpty && (!txCharValid || txCharTake)
		&& uartControl[CTRL_EN] && uartControl[CTRL_TXE];

	uirm_fifo #(
		.WIDTH (RXW),
		.DEPTH (FIFO_DEPTH)
	) rxFifo (
		.clk      (sys_clk),
		.rst      (rst),
		.ce       (ce),
		.limit    (rxLimit),
		.push     (rxPush),
		.pushData ({lineBreakFault, parityFault, framingFault, rxChar}),
		.pop      (rxPop),
		.popData  (rxHead),
		.count    (rxCount),
		.full     (rxFull),
		.empty    (rxEmpty)
	);

	uirm_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) txFifo (
		.clk      (sys_clk),
		.rst      (rst),
		.ce       (ce),
		.limit    (txLimit),
		.push     (txPush),
		.pushData (pwdata[CHAR_W-1:0]),
		.pop      (txPop),
		.popData  (txHead),
		.count    (txCount),
		.full     (txFull),
		.empty    (txEmpty)
	);

	// Level conditions behind the service interrupts
	always_comb begin
		if (rxLineFormat[FEN_BIT])
			rxCond = rxCount >= wmLevel(threshold_r[THR_RX_LSB +: 3]);
		else
			rxCond = rxCount != '0;
		if (txLineFormat[FEN_BIT])
			txCond = txCount < wmLevel(threshold_r[THR_TX_LSB +: 3]);
		else
			txCond = txCount == '0;
	end

	assign busy = txCharValid || txShiftBusy;

	// Fires once as the idle count reaches the timeout; zero disables it
	assign rtSet = bitTick && !rxEmpty && !rxCharValid && !rxStartBit
		&& idleTimeout_r != '0
		&& idleCnt_r + 32'h1 == idleTimeout_r;

	// Sources set and clear; a set in the same cycle beats the clear
	always_comb begin
		irqSet = '0;
		irqClr = '0;
		irqSet[IRQ_RX]   = rxCond && !rxCondPrev_r;
		// Only a pop drives the level transition, never an enable
		irqSet[IRQ_TX]   = txCond && !txCondPrev_r && txPopPrev_r;
		irqSet[IRQ_RT]   = rtSet;
		irqSet[IRQ_FE]   = rxPush && framingFault;
		irqSet[IRQ_PE]   = rxPush && parityFault;
		irqSet[IRQ_BE]   = rxPush && lineBreakFault;
		irqSet[IRQ_OE]   = rxOverrun;
		irqSet[IRQ_TXFE] = busyPrev_r && !busy && txEmpty;
		if (wrAcc && ofs == OFS_ICLR)
			irqClr = pwdata[IRQ_W-1:0];
		irqClr[IRQ_RX] = irqClr[IRQ_RX] || !rxCond;
		irqClr[IRQ_TX] = irqClr[IRQ_TX] || !txCond;
		irqClr[IRQ_RT] = irqClr[IRQ_RT] || rxEmpty;
		irqRaw_nxt = (irqRaw_r & ~irqClr) | irqSet;
	end

	// Read mux, sampled into prdata on the same edge that raises pready
	always_comb begin
		rdData = '0;
		case (ofs)
			OFS_DATA:  rdData = {20'h0, errStatus_r[ERR_OE], rxHead};
			OFS_ERR:   rdData = {28'h0, errStatus_r};
			OFS_TMO:   rdData = idleTimeout_r;
			OFS_FLAGS: rdData = lineFlags_r;
			OFS_RXFMT: rdData = rxLineFormat;
			OFS_BAUDI: rdData = baudDivInt;
			OFS_BAUDF: rdData = baudDivFrac;
			OFS_TXFMT: rdData = txLineFormat;
			OFS_CTRL:  rdData = uartControl;
			OFS_THR:   rdData = threshold_r;
			OFS_MASK:  rdData = 32'(irqMask_r);
			OFS_RAW:   rdData = 32'(irqRaw_r);
			OFS_MIS:   rdData = 32'(irqRaw_r & irqMask_r);
			OFS_DMA:   rdData = dmaRequestControl;
			OFS_SFC:   rdData = softFlowControl;
			default: begin
				if (ofs >= OFS_RES1 && ofs <= OFS_PAU2)
					rdData = 32'(flowChar_r[charIdx]);
			end
		endcase
		if (!hit)
			rdData = '0;
	end

	// APB slave: one wait state, error on unmapped or misaligned access
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			prdata  <= rdData;
		end
	end

	// Software-written configuration
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idleTimeout_r     <= RST_TMO;
			uartControl       <= RST_CTRL;
			threshold_r       <= RST_THR;
			irqMask_r         <= '0;
			rxLineFormat      <= '0;
			txLineFormat      <= '0;
			baudDivInt        <= '0;
			baudDivFrac       <= '0;
			dmaRequestControl <= '0;
			softFlowControl   <= '0;
		end else if (ce && wrAcc) begin
			case (ofs)
				OFS_TMO:   idleTimeout_r     <= pwdata;
				OFS_CTRL:  uartControl       <= pwdata;
				OFS_THR:   threshold_r       <= pwdata;
				OFS_MASK:  irqMask_r         <= pwdata[IRQ_W-1:0];
				OFS_RXFMT: rxLineFormat      <= pwdata;
				OFS_TXFMT: txLineFormat      <= pwdata;
				OFS_BAUDI: baudDivInt        <= pwdata;
				OFS_BAUDF: baudDivFrac       <= pwdata;
				OFS_DMA:   dmaRequestControl <= pwdata;
				OFS_SFC:   softFlowControl   <= pwdata;
				default: ;
			endcase
		end
	end

	// Flow-control characters keep only their low byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				flowChar_r[i] <= '0;
		end else if (ce && wrAcc && ofs >= OFS_RES1 && ofs <= OFS_PAU2) begin
			flowChar_r[charIdx] <= pwdata[CHAR_W-1:0];
		end
	end

	// Sticky receive faults; a new fault beats a clearing write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			errStatus_r <= '0;
		end else if (ce) begin
			if (wrAcc && ofs == OFS_ERR)
				errStatus_r <= '0;
			if (rxPush && framingFault)
				errStatus_r[ERR_FE] <= 1'b1;
			if (rxPush && parityFault)
				errStatus_r[ERR_PE] <= 1'b1;
			if (rxPush && lineBreakFault)
				errStatus_r[ERR_BE] <= 1'b1;
			if (rxOverrun)
				errStatus_r[ERR_OE] <= 1'b1;
		end
	end

	// Interrupt state and the single combined output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqRaw_r     <= '0;
			uartIrq      <= 1'b0;
			rxCondPrev_r <= 1'b0;
			txCondPrev_r <= 1'b0;
			txPopPrev_r  <= 1'b0;
			busyPrev_r   <= 1'b0;
		end else if (ce) begin
			irqRaw_r     <= irqRaw_nxt;
			// Output trails the raw status by one cycle
			uartIrq      <= |(irqRaw_r & irqMask_r);
			rxCondPrev_r <= rxCond;
			txCondPrev_r <= txCond;
			txPopPrev_r  <= txPop;
			busyPrev_r   <= busy;
		end
	end

	// Idle counter in bit periods, restarted by any receive activity
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idleCnt_r <= '0;
		end else if (ce) begin
			if (rxEmpty || rxCharValid || rxStartBit)
				idleCnt_r <= '0;
			else if (bitTick && idleCnt_r < idleTimeout_r)
				idleCnt_r <= idleCnt_r + 32'h1;
		end
	end

	// Transmit holding stage toward the serial engine
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txCharValid <= 1'b0;
			txChar      <= '0;
		end else if (ce) begin
			if (txPop) begin
				txCharValid <= 1'b1;
				txChar      <= txHead;
			end else if (txCharTake) begin
				txCharValid <= 1'b0;
			end
		end
	end

	// Line flags rebuilt every cycle from FIFO and shifter state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lineFlags_r <= RST_FLAGS;
		end else if (ce) begin
			lineFlags_r           <= FLG_FIXED;
			lineFlags_r[FLG_BUSY] <= busy;
			lineFlags_r[FLG_RXFE] <= rxEmpty;
			lineFlags_r[FLG_TXFF] <= txFull;
			lineFlags_r[FLG_RXFF] <= rxFull;
			lineFlags_r[FLG_TXFE] <= txEmpty;
		end
	end
endmodule // uirm_regmap

// ==== verification/uirm_regmap_properties.sv ====
// Checker of the serial port register block, on its ports only.
// Assumes a bind onto every uirm_regmap instance.
`timescale 1ns/100ps
module uirm_regmap_properties import uirm_pkg::*; (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic [31:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txCharValid,
	input wire logic        txCharTake,
	input wire logic [7:0]  txChar,
	input wire logic        uartIrq,
	input wire logic [31:0] uartControl,
	input wire logic [31:0] baudDivInt
);
	localparam logic [31:0] A_CTRL = BASE_ADDR | 32'(OFS_CTRL);
	localparam logic [31:0] A_MASK = BASE_ADDR | 32'(OFS_MASK);
	logic        done;
	logic [31:0] maskCopy_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	assign done = ce && psel && penable && pready && !pslverr;
	// Shadow of the mask as software last wrote it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			maskCopy_r <= 32'h0;
		else if (done && pwrite && paddr == A_MASK)
			maskCopy_r <= pwdata;
	end
	a_answer_time: assert property (psel && penable && !$past(penable) && ce
		##1 ce |-> pready) else $error("no answer in access phase");
	a_answer_pulse: assert property (pready && ce |=> !pready)
		else $error("answer longer than one cycle");
	a_outside_refused: assert property (psel && penable && !pready &&
		paddr[31:7] != BASE_ADDR[31:7] ##1 ce |-> pready && pslverr &&
		prdata == 32'h0) else $error("outside access not refused");
	a_control_taken: assert property (psel && penable && !pready &&
		paddr == A_CTRL ##1 ce |-> pready && !pslverr)
		else $error("control access refused");
	a_reset_values: assert property ($fell(rst) |-> !uartIrq &&
		uartControl == RST_CTRL && baudDivInt == 32'h0)
		else $error("wrong value after reset");
	a_mask_gates_irq: assert property (maskCopy_r == 32'h0 &&
		$past(maskCopy_r) == 32'h0 |-> !uartIrq)
		else $error("interrupt with all sources masked");
	a_tx_loads: assert property (done && pwrite && paddr == BASE_ADDR &&
		!txCharValid && uartControl[CTRL_EN] && uartControl[CTRL_TXE]
		|-> ##[1:3] txCharValid) else $error("written character not offered");
	a_tx_holds: assert property (txCharValid && !txCharTake |=>
		txCharValid && $stable(txChar)) else $error("character lost");
endmodule // uirm_regmap_properties
bind uirm_regmap uirm_regmap_properties chk_i (.sys_clk(sys_clk), .rst(rst),
	.ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .txCharValid(txCharValid), .txCharTake(txCharTake),
	.txChar(txChar), .uartIrq(uartIrq), .uartControl(uartControl),
	.baudDivInt(baudDivInt));

// ==== verification/uirm_engine_model.sv ====
// Model of the serial engine beside the register block.
// Assumes the bench calls send_rx and drives hold to stall transmit.
`timescale 1ns/100ps
module uirm_engine_model (
	input  wire logic       sys_clk,
	input  wire logic       hold,
	input  wire logic       txCharValid,
	output logic            txCharTake,
	output logic            txShiftBusy,
	output logic            rxCharValid,
	output logic [7:0]      rxChar,
	output logic            framingFault,
	output logic            parityFault,
	output logic            lineBreakFault,
	output logic            rxStartBit,
	output logic            bitTick
);
	int busyCnt = 0;
	initial begin
		{txCharTake, txShiftBusy, rxCharValid, rxStartBit, bitTick} = '0;
		{rxChar, framingFault, parityFault, lineBreakFault} = '0;
	end
	// One shift register, so a new take waits for the last character
	always @(posedge sys_clk) begin
		bitTick <= !bitTick;
		txCharTake <= txCharValid && busyCnt == 0 && !txCharTake && !hold;
		// Shifter busy from the take edge on, so busy never dips early
		if (txCharValid && busyCnt == 0 && !txCharTake && !hold) begin
			busyCnt <= 16;
			txShiftBusy <= 1'b1;
		end else begin
			if (busyCnt > 0)
				busyCnt <= busyCnt - 1;
			txShiftBusy <= busyCnt > 1;
		end
	end
	// Lines outside a character show its inverse, never a stale copy
	task automatic send_rx(input logic [7:0] c, input logic [2:0] f);
		@(posedge sys_clk);
		rxStartBit <= 1'b1;
		@(posedge sys_clk);
		rxStartBit <= 1'b0;
		rxCharValid <= 1'b1;
		rxChar <= c;
		{lineBreakFault, parityFault, framingFault} <= f;
		@(posedge sys_clk);
		rxCharValid <= 1'b0;
		rxChar <= ~c;
		{lineBreakFault, parityFault, framingFault} <= ~f;
	endtask
endmodule // uirm_engine_model

// ==== verification/tb_top.sv ====
// Self-checking bench of the serial port register block.
// Assumes the bound checker and the engine model beside the block.
`timescale 1ns/100ps
module tb_top import uirm_pkg::*; ;
	localparam int DEPTH = 16;
	localparam int LVL = DEPTH / 2;
	localparam logic [6:0] R_OFS[8] = '{OFS_TMO, OFS_FLAGS, OFS_CTRL,
		OFS_THR, OFS_MASK, OFS_RAW, OFS_MIS, OFS_ERR};
	localparam logic [31:0] R_VAL[8] = '{RST_TMO, RST_FLAGS, RST_CTRL,
		RST_THR, 32'h0, 32'h0, 32'h0, 32'h0};
	logic        sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, seed;
	logic        rxCharValid, framingFault, parityFault, lineBreakFault;
	logic        rxStartBit, bitTick, txCharTake, txShiftBusy, txHold;
	logic        txCharValid, uartIrq;
	logic [7:0]  rxChar, txChar, c;
	logic [64:0] expQ[$], e;
	logic [7:0]  rxQ[$], txQ[$];
	int          miscompares, cmpCount;

	uirm_regmap #(.FIFO_DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .rst(rst),
		.ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxCharValid(rxCharValid), .rxChar(rxChar),
		.framingFault(framingFault), .parityFault(parityFault),
		.lineBreakFault(lineBreakFault), .rxStartBit(rxStartBit),
		.bitTick(bitTick), .txCharTake(txCharTake),
		.txShiftBusy(txShiftBusy), .txCharValid(txCharValid),
		.txChar(txChar), .uartIrq(uartIrq), .uartControl(),
		.rxLineFormat(), .txLineFormat(), .baudDivInt(), .baudDivFrac(),
		.dmaRequestControl(), .softFlowControl());
	uirm_engine_model model (.sys_clk(sys_clk), .hold(txHold),
		.txCharValid(txCharValid), .txCharTake(txCharTake),
		.txShiftBusy(txShiftBusy), .rxCharValid(rxCharValid),
		.rxChar(rxChar), .framingFault(framingFault),
		.parityFault(parityFault), .lineBreakFault(lineBreakFault),
		.rxStartBit(rxStartBit), .bitTick(bitTick));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finishTest();
		$display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Request held until the edge that samples pready high
	task automatic apb(input logic [31:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] m, input logic er);
		expQ.push_back({er, m, d & m});
		@(posedge sys_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge sys_clk);
		while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [6:0] o, input logic [31:0] d);
		apb(BASE_ADDR | 32'(o), 1'b1, d, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [6:0] o, input logic [31:0] v);
		apb(BASE_ADDR | 32'(o), 1'b0, v, 32'hFFFFFFFF, 1'b0);
	endtask
	// Overrun bit of a data read is left out: it mirrors the sticky overrun status
	task automatic rdData(input logic [2:0] f);
		apb(BASE_ADDR, 1'b0, {21'h0, f, rxQ.pop_front()}, 32'h7FF, 1'b0);
	endtask
	task automatic rxSend(input logic [2:0] f, input logic keep);
		c = rnd();
		if (keep)
			rxQ.push_back(c);
		model.send_rx(c, f);
	endtask
	task automatic drainTx();
		while (txQ.size() != 0)
			@(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk)
		if (psel && penable && pready) begin
			e = expQ.pop_front();
			chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
		end
	always @(posedge sys_clk)
		if (txCharValid && txCharTake)
			chk(txChar, txQ.size() ? txQ.pop_front() : ~txChar);
	initial begin
		repeat (50000) @(posedge sys_clk);
		miscompares++;
		finishTest();
	end

	initial begin
		{rst, ce, txHold} = 3'b111;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 32'hDF9D;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (R_OFS[i]) rd(R_OFS[i], R_VAL[i]);
		for (int o = 'h54; o <= 'h60; o += 4) begin
			rd(7'(o), 32'h0);
			wr(7'(o), {24'hC3C3C3, rnd()});
			rd(7'(o), {24'h0, seed[7:0]});
		end
		foreach (R_VAL[i]) if (i < 3)
			apb(BASE_ADDR | (32'h2 << (i * 3)), i[0], 32'h0, 32'hFFFFFFFF, 1'b1);
		wr(OFS_FLAGS, 32'hFFFFFFFF);
		rd(OFS_FLAGS, RST_FLAGS);
		wr(OFS_THR, 32'h1A);
		rd(OFS_THR, 32'h1A);
		wr(OFS_THR, RST_THR);
		wr(OFS_TMO, 32'h0);
		rd(OFS_TMO, 32'h0);
		wr(OFS_RXFMT, 32'h10);
		wr(OFS_TXFMT, 32'h10);
		wr(OFS_CTRL, 32'h301);
		rd(OFS_CTRL, 32'h301);
		wr(OFS_MASK, 32'h17F0);
		rd(OFS_RAW, 32'h0);
		for (int i = 1; i <= LVL; i++) begin
			rxSend(3'b0, 1'b1);
			rd(OFS_RAW, i == LVL ? 32'h10 : 32'h0);
		end
		rd(OFS_MIS, 32'h10);
		chk(uartIrq, 1'b1);
		rdData(3'b0);
		rd(OFS_RAW, 32'h0);
		rxSend(3'b0, 1'b1);
		rd(OFS_RAW, 32'h10);
		wr(OFS_ICLR, 32'h10);
		rd(OFS_RAW, 32'h0);
		repeat (LVL) rdData(3'b0);
		chk(uartIrq, 1'b0);
		for (int i = 0; i < 3; i++) begin
			rxSend(3'(1 << i), 1'b1);
			rd(OFS_RAW, 32'h80 << i);
			rd(OFS_ERR, 32'h1 << i);
			wr(OFS_ICLR, 32'h80 << i);
			wr(OFS_ERR, 32'h0);
			rd(OFS_ERR, 32'h0);
			rd(OFS_RAW, 32'h0);
			rdData(3'(1 << i));
		end
		for (int i = 0; i <= DEPTH; i++) rxSend(3'b0, i < DEPTH);
		rd(OFS_RAW, 32'h410);
		rd(OFS_ERR, 32'h8);
		wr(OFS_ICLR, 32'h410);
		wr(OFS_ERR, 32'h0);
		rd(OFS_RAW, 32'h0);
		repeat (DEPTH) rdData(3'b0);
		wr(OFS_TMO, 32'h4);
		rxSend(3'b0, 1'b1);
		// Frozen clock enable must hold the idle count still
		ce <= 1'b0;
		repeat (12) @(posedge sys_clk);
		ce <= 1'b1;
		rd(OFS_RAW, 32'h0);
		repeat (20) @(posedge sys_clk);
		rd(OFS_RAW, 32'h40);
		rdData(3'b0);
		rd(OFS_RAW, 32'h0);
		wr(OFS_TMO, 32'h0);
		for (int i = 0; i < DEPTH; i++) begin
			txQ.push_back(rnd());
			wr(OFS_DATA, {24'h0, seed[7:0]});
		end
		rd(OFS_RAW, 32'h0);
		txHold <= 1'b0;
		drainTx();
		rd(OFS_RAW, 32'h1020);
		wr(OFS_ICLR, 32'h1020);
		rd(OFS_RAW, 32'h0);
		wr(OFS_TXFMT, 32'h0);
		wr(OFS_RXFMT, 32'h0);
		txHold <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			txQ.push_back(rnd());
			wr(OFS_DATA, {24'h0, seed[7:0]});
			rd(OFS_RAW, i == 0 ? 32'h20 : 32'h0);
		end
		txHold <= 1'b0;
		drainTx();
		rd(OFS_RAW, 32'h1020);
		wr(OFS_ICLR, 32'h1020);
		rd(OFS_RAW, 32'h0);
		rxSend(3'b0, 1'b1);
		rd(OFS_RAW, 32'h10);
		rdData(3'b0);
		rd(OFS_RAW, 32'h0);
		rxSend(3'b0, 1'b1);
		wr(OFS_MASK, 32'h0);
		rd(OFS_MIS, 32'h0);
		chk(uartIrq, 1'b0);
		rd(OFS_RAW, 32'h10);
		rdData(3'b0);
		finishTest();
	end
endmodule // tb_top
